// file: dv/tb_tcm_timer.sv
// self-checking bench for the timer channel block
module tb_tcm_timer
  import tcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] VH0 = ADDR_CH0 + {4'h0, CH_VH}; // value high
  localparam logic [7:0] VL0 = ADDR_CH0 + {4'h0, CH_VL}; // value low
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        tick;      // counting tick
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;        // last read data
  logic        pready;
  logic        pslverr;
  logic        overflow_irq;
  logic [1:0]  chan_irq;
  logic [1:0]  pin_in;    // resolved pins
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe_n;
  logic [1:0]  drive_lvl; // outside source level
  int          n_mismatch;
  int          samples_checked;
  tcm_timer #(.NCH(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prescale_tick(tick), .chan_pin_in(pin_in),
    .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n), .overflow_irq, .chan_irq);
  tcm_pin_model #(.NCH(2)) u_pins (.drive_lvl, .pin_out, .pin_oe_n, .pin(pin_in));
  // 50 ns bus clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t saw %h want %h", $time, s, e);
    end
  endtask
  // one bus transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      tick <= 1'b1;
    end
    @(posedge pclk);
    tick <= 1'b0;
  endtask
  task automatic pin_to(input logic [1:0] v);
    @(posedge pclk);
    drive_lvl <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_reset;
    check(32'(pin_oe_n), 32'h3);
    rdc(ADDR_TSC, 8'h00);
    rdc(ADDR_CH0, 8'h00);
    wr(8'hFC, 8'h5A);
    rdc(8'hFC, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_capture;
    wr(ADDR_CH0, 8'h44);
    wr(ADDR_CNTH, 8'h00);
    wr(ADDR_TSC, 8'h08);
    ticks(19);
    pin_to(2'b11);
    rdc(ADDR_CH0, 8'hC4);
    check(32'(chan_irq), 32'h1);
    rdc(VH0, 8'h00);
    rdc(VL0, 8'h13);
    wr(VL0, 8'hAA);
    rdc(VL0, 8'h13);
    rdc(ADDR_CH0, 8'hC4);
    wr(ADDR_CH0, 8'h0C);
    rdc(ADDR_CH0, 8'h0C);
    pin_to(2'b00);
    rdc(ADDR_CH0, 8'h8C);
    check(32'(chan_irq), 32'h0);
    wr(ADDR_CH0, 8'h08);
    pin_to(2'b11);
    rdc(ADDR_CH0, 8'h08);
    pin_to(2'b00);
    rdc(ADDR_CH0, 8'h88);
    rdc(ADDR_CH0 + CH_STRIDE, 8'h00);
    $display("capture test done");
  endtask
  task automatic t_compare;
    logic [7:0] md [3];
    md = '{8'h1C, 8'h18, 8'h14};
    wr(ADDR_TSC, 8'h00);
    wr(ADDR_CH0, 8'h1C);
    wr(VH0, 8'h00);
    wr(VL0, 8'h05);
    wr(ADDR_TSC, 8'h08);
    // set, clear, then toggle back up
    for (int i = 0; i < 3; i++)
    begin
      // read then write zero drops the old flag
      apb(1'b0, ADDR_CH0, 8'h00);
      wr(ADDR_CH0, md[i]);
      wr(ADDR_CNTH, 8'h00);
      ticks(7);
      check(32'(pin_out[0]), 32'(i != 1));
      rdc(ADDR_CH0, md[i] | 8'h80);
    end
    $display("compare test done");
  endtask
  task automatic pwm_setup(input logic [7:0] tsc, input logic [7:0] m);
    wr(ADDR_TSC, 8'h00);
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_MODL, m);
    // restart so the counter starts below the new modulus
    wr(ADDR_CNTL, 8'h00);
    wr(ADDR_TSC, tsc);
    @(posedge pclk);
    tick <= 1'b1;
  endtask
  // duty measured over whole periods after the buffer has loaded
  task automatic pwm_step(input logic [7:0] sc, input logic [15:0] v, input int e);
    int h;
    h = 0;
    wr(ADDR_CH0, sc);
    wr(VH0, v[15:8]);
    wr(VL0, v[7:0]);
    repeat (20) @(posedge pclk);
    repeat (80)
    begin
      @(negedge pclk);
      h += int'(pin_out[0] === 1'b1);
    end
    check(32'(h), 32'(e));
  endtask
  task automatic t_ovf;
    wr(ADDR_TSC, 8'h48);
    repeat (3) @(posedge pclk);
    check(32'(overflow_irq), 32'h1);
    @(posedge pclk);
    tick <= 1'b0;
    rdc(ADDR_TSC, 8'hC8);
    wr(ADDR_TSC, 8'h48);
    rdc(ADDR_TSC, 8'h48);
    check(32'(overflow_irq), 32'h0);
    $display("overflow test done");
  endtask
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tick = 1'b0;
    drive_lvl = 2'b00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capture();
    t_compare();
    pwm_setup(8'h08, 8'h03);
    pwm_step(8'h28, 16'h0001, 20);
    pwm_step(8'h28, 16'h0000, 0);
    pwm_step(8'h28, 16'h0005, 80);
    pwm_step(8'h2C, 16'h0001, 60);
    $display("edge pwm test done");
    t_ovf();
    // modulus 4 in range, only channel 0 active
    pwm_setup(8'h28, 8'h04);
    pwm_step(8'h28, 16'h0002, 40);
    pwm_step(8'h28, 16'h0000, 0);
    pwm_step(8'h28, 16'h8001, 0);
    pwm_step(8'h28, 16'h0005, 80);
    pwm_step(8'h2C, 16'h0001, 60);
    $display("center pwm test done");
    print_verdict();
  end
endmodule // tb_tcm_timer

bind tcm_timer tcm_timer_sva #(.NCH(NCH)) u_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .chan_pin_oe_n, .overflow_irq, .chan_irq);

// file: dv/tcm_pin_model.sv
// outside pin source: drives capture levels, yields while the timer drives
module tcm_pin_model
#(
  parameter int NCH = 2 // channel count
)
(
  input  wire logic [NCH-1:0] drive_lvl, // level from the outside source
  input  wire logic [NCH-1:0] pin_out,   // timer drive level
  input  wire logic [NCH-1:0] pin_oe_n,  // low while the timer drives
  output logic      [NCH-1:0] pin        // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin follows the outside source
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      pin[i] = pin_oe_n[i] ? drive_lvl[i] : pin_out[i];
    end
  end
endmodule // tcm_pin_model

// file: dv/tcm_timer_sva.sv
// port checks for the timer channel block
module tcm_timer_sva
  import tcm_pkg::*;
#(
  parameter int NCH = 2 // channel count
)
(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [NCH-1:0] chan_pin_oe_n,
  input wire logic           overflow_irq,
  input wire logic [NCH-1:0] chan_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // completed write; reads that show an enable clear
  wire logic wr_ok  = pwrite && pready;
  wire logic rd_tsc = pready && !pwrite && paddr == ADDR_TSC && !prdata[TSC_OVIE];
  wire logic rd_ch0 = pready && !pwrite && paddr == ADDR_CH0 && !prdata[CSC_IE];
  // setup answered in the next cycle, no wait state
  property p_wait;
    psel && !penable |=> pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("no answer after setup");
  // answer lasts one cycle, never an error
  property p_pulse;
    pready |-> penable && !pslverr && prdata[31:8] == 24'h000000 ##1 !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("bad answer pulse");
  property p_rst;
    $rose(presetn) |-> &chan_pin_oe_n && !overflow_irq && chan_irq == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  // pin drive follows configuration writes only
  property p_oe;
    $changed(chan_pin_oe_n) |-> $past(wr_ok) || $past(wr_ok, 2);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable moved without a write");
  property p_ovf_gate;
    rd_tsc |=> !overflow_irq;
  endproperty
  a_ovf_gate: assert property (p_ovf_gate)
    else $error("overflow request while disabled");
  property p_ch_gate;
    rd_ch0 |=> !chan_irq[0];
  endproperty
  a_ch_gate: assert property (p_ch_gate)
    else $error("channel request while disabled");
  // flags drop only after a write
  property p_ovf_clr;
    $fell(overflow_irq) |-> $past(wr_ok) || $past(wr_ok, 2);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow request fell unprompted");
  property p_ch_clr;
    $fell(chan_irq[0]) |-> $past(wr_ok) || $past(wr_ok, 2);
  endproperty
  a_ch_clr: assert property (p_ch_clr)
    else $error("channel request fell unprompted");
endmodule // tcm_timer_sva

// file: rtl/tcm_pkg.sv
// constants for the timer channel block: register map, fields, reset values
package tcm_pkg;
  // register byte offsets (one aligned word each, data in low 8 bits)
  localparam logic [7:0] ADDR_TSC   = 8'h00; // timer_status_control
  localparam logic [7:0] ADDR_CNTH  = 8'h04; // count_high
  localparam logic [7:0] ADDR_CNTL  = 8'h08; // count_low
  localparam logic [7:0] ADDR_MODH  = 8'h0C; // modulus_high
  localparam logic [7:0] ADDR_MODL  = 8'h10; // modulus_low
  localparam logic [7:0] ADDR_DBG   = 8'h14; // debug mode control
  localparam logic [7:0] ADDR_CH0   = 8'h20; // first channel block
  localparam logic [7:0] CH_STRIDE  = 8'h10; // bytes per channel block
  localparam logic [3:0] CH_SC      = 4'h0;  // chan_status_control
  localparam logic [3:0] CH_VH      = 4'h4;  // chan_value_high
  localparam logic [3:0] CH_VL      = 4'h8;  // chan_value_low
  // timer_status_control fields
  localparam int TSC_OVF   = 7;
  localparam int TSC_OVIE  = 6;
  localparam int TSC_CAS   = 5;
  localparam int TSC_CLKHI = 4;
  localparam int TSC_CLKLO = 3;
  // chan_status_control fields
  localparam int CSC_FLAG  = 7;
  localparam int CSC_IE    = 6;
  localparam int CSC_MSB   = 5;
  localparam int CSC_MSA   = 4;
  localparam int CSC_ELB   = 3;
  localparam int CSC_ELA   = 2;
  localparam logic [7:0]  TSC_RESET = 8'h00;
  localparam logic [7:0]  CSC_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  // channel modes derived from mode-select bits
  typedef enum logic [1:0]
  {
    TCM_CAPTURE = 2'b00,
    TCM_COMPARE = 2'b01,
    TCM_EDGE_ALIGNED_PWM    = 2'b10,
    TCM_CENTER_ALIGNED_PWM    = 2'b11
  } tcm_mode_t;
endpackage : tcm_pkg

// file: rtl/tcm_timer.sv
// timer counter with per-channel capture, compare and pwm, apb register access
// Function
// - mode bits pick capture, compare or edge_aligned_pwm
// - active edge copies counter into value
// - edge bits select rising, falling, both, none
// - value bytes read-only during capture
// - reading one byte latches the other
// - capture sets flag, gated interrupt
// - capture works during debug freeze
// - compare match sets, clears or toggles pin
// - compare value buffered, loads after both bytes
// - status/control write abandons half write
// - compare match sets flag, gated interrupt
// - edge_aligned_pwm period modulus plus one
// - overflow sets, match clears, level inverts
// - zero gives 0%, above modulus 100%
// - pwm buffer loads at modulus minus one
// - center pwm counts up and down
// - up match clears, down match sets
// - zero or negative value gives 0%
// - reset clears control, channels capture, pins released
// - flags gated onto active-high interrupts
// - flag clears by read-then-write-zero
// - center_aligned_pwm sets flag at both matches
module tcm_timer
  import tcm_pkg::*;
#(
  parameter int NCH = 2 // number of channels
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              prescale_tick,  // counting tick from prescaler
  input  wire logic [NCH-1:0]    chan_pin_in,    // pin levels, asynchronous
  output logic      [NCH-1:0]    chan_pin_out,   // pin drive level
  output logic      [NCH-1:0]    chan_pin_oe_n,  // low while the pin is driven
  output logic                   overflow_irq,
  output logic      [NCH-1:0]    chan_irq
);

  logic [7:0]  tsc;                 // timer_status_control less flag
  logic        overflow_flag;       // sticky overflow
  logic        ovf_armed;           // flag read while set
  logic [15:0] count;               // main counter
  logic        count_down;          // direction in center mode
  logic [15:0] modulus;             // terminal count, 0 means free run
  logic        debug_mode;          // background debug freeze
  logic [7:0]  csc      [NCH];      // chan_status_control less flag
  logic        chan_event_flag [NCH];
  logic        chan_armed [NCH];
  logic [15:0] cval     [NCH];      // active channel value
  logic [15:0] wbuf     [NCH];      // write buffer
  logic [1:0]  wseen    [NCH];      // bytes written: bit1 high, bit0 low
  logic        wfull    [NCH];      // both bytes in, waiting for load
  logic [7:0]  rhold    [NCH];      // other half latched on read
  logic [1:0]  rstate   [NCH];      // 01 low held, 10 high held
  logic [NCH-1:0] sync1, sync2, sync3; // pin synchroniser and history

  // bus access strobes; zero-wait slave
  logic        wr_en, rd_en;
  logic        clk_on, center, tick;
  logic        at_top, hit_mod_m1;
  logic [15:0] term;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign clk_on = tsc[TSC_CLKHI] | tsc[TSC_CLKLO];
  assign center = tsc[TSC_CAS];
  assign tick   = clk_on & prescale_tick & ~debug_mode; // counter frozen in debug
  assign term   = (modulus == 16'h0000) ? CNT_TOP : modulus;
  assign at_top = (count == term);
  assign hit_mod_m1 = tick & ~count_down & (count == term - 16'h0001);

  // decode channel register from the address
  function automatic logic chan_hit(input logic [7:0] a, input int n, input logic [3:0] r);
    logic [7:0] base;
    base = ADDR_CH0 + 8'(n) * CH_STRIDE;
    return a == (base + {4'h0, r});
  endfunction

  // mode bits pick channel function
  // effective channel mode; center mode overrides per-channel bits
  function automatic tcm_mode_t chan_mode(input logic [7:0] c, input logic cas);
    if (cas)
      return TCM_CENTER_ALIGNED_PWM;
    else if (c[CSC_MSB])
      return TCM_EDGE_ALIGNED_PWM;
    else if (c[CSC_MSA])
      return TCM_COMPARE;
    else
      return TCM_CAPTURE;
  endfunction

  // apb answers in the access cycle, never an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
    end
  end

  // timer control and overflow flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsc           <= TSC_RESET;
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
      modulus       <= MOD_RESET;
      debug_mode    <= 1'b0;
    end
    else
    begin
      if (wr_en && pready && paddr == ADDR_TSC)
        tsc <= {1'b0, pwdata[TSC_OVIE:TSC_CLKLO], 3'b000};
      if (wr_en && pready && paddr == ADDR_MODH)
        modulus[15:8] <= pwdata[7:0];
      if (wr_en && pready && paddr == ADDR_MODL)
        modulus[7:0] <= pwdata[7:0];
      if (wr_en && pready && paddr == ADDR_DBG)
        debug_mode <= pwdata[0];
      // read while set arms the clear
      if (rd_en && pready && paddr == ADDR_TSC && overflow_flag)
        ovf_armed <= 1'b1;
      // terminal count sets overflow; set wins over clear
      if (tick && at_top && (center ? ~count_down : 1'b1))
      begin
        overflow_flag <= 1'b1;
        ovf_armed     <= 1'b0;
      end
      else if (wr_en && pready && paddr == ADDR_TSC && !pwdata[TSC_OVF] && ovf_armed)
      begin
        overflow_flag <= 1'b0;
        ovf_armed     <= 1'b0;
      end
    end
  end

  // main counter; any write to either count byte restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count      <= 16'h0000;
      count_down <= 1'b0;
    end
    else if (wr_en && pready && (paddr == ADDR_CNTH || paddr == ADDR_CNTL))
    begin
      count      <= 16'h0000;
      count_down <= 1'b0;
    end
    else if (tick)
    begin
      // up to modulus then back down to zero
      if (center)
      begin
        if (!count_down && at_top)
        begin
          count_down <= 1'b1;
          count      <= count - 16'h0001;
        end
        else if (count_down && count == 16'h0000)
        begin
          count_down <= 1'b0;
          count      <= count + 16'h0001;
        end
        else if (count_down)
          count <= count - 16'h0001;
        else
          count <= count + 16'h0001;
      end
      // up count wraps after terminal, period modulus plus one
      else
      begin
        count_down <= 1'b0;
        count      <= at_top ? 16'h0000 : count + 16'h0001;
      end
    end
  end

  // two-flop synchroniser plus history stage for edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= chan_pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // per-channel logic
  for (genvar n = 0; n < NCH; n++)
  begin : g_ch
    tcm_mode_t mode;
    logic      rise, fall, cap_ev, match, cmp_ev, ev;
    logic      wr_sc, wr_vh, wr_vl, rd_vh, rd_vl, load;
    logic      elb, ela, edge_aligned_pwm_fall;
    assign mode  = chan_mode(csc[n], center);
    assign elb   = csc[n][CSC_ELB];
    assign ela   = csc[n][CSC_ELA];
    assign rise  = sync2[n] & ~sync3[n];
    assign fall  = ~sync2[n] & sync3[n];
    assign wr_sc = wr_en & pready & chan_hit(paddr, n, CH_SC);
    assign wr_vh = wr_en & pready & chan_hit(paddr, n, CH_VH);
    assign wr_vl = wr_en & pready & chan_hit(paddr, n, CH_VL);
    assign rd_vh = rd_en & pready & chan_hit(paddr, n, CH_VH);
    assign rd_vl = rd_en & pready & chan_hit(paddr, n, CH_VL);
    // rising, falling or both; 00 leaves pin alone
    // edges still captured while frozen in debug
    assign cap_ev = (mode == TCM_CAPTURE) & ((elb & fall) | (ela & rise));
    // match is judged once per counting tick
    assign match  = tick & (count == cval[n]);
    assign cmp_ev = (mode != TCM_CAPTURE) & match;
    // edge_aligned_pwm drops as the counter steps onto the value, so duty is cval counts
    assign edge_aligned_pwm_fall = tick & ((count + 16'h0001) == cval[n]);
    assign ev     = cap_ev | cmp_ev;
    // compare loads on next tick, no clock loads at once
    // pwm modes load at modulus minus one step
    assign load = wfull[n] & (~clk_on | debug_mode |
                  ((mode == TCM_COMPARE) ? tick : hit_mod_m1));

    // control, flag and value registers
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        // channels start in capture, pin released
        csc[n]             <= CSC_RESET;
        chan_event_flag[n] <= 1'b0;
        chan_armed[n]      <= 1'b0;
        cval[n]            <= 16'h0000;
        wbuf[n]            <= 16'h0000;
        wseen[n]           <= 2'b00;
        wfull[n]           <= 1'b0;
      end
      else
      begin
        if (wr_sc)
          csc[n] <= {1'b0, pwdata[CSC_IE:CSC_ELA], 2'b00};
        // read while set arms the clear
        if (rd_en && pready && chan_hit(paddr, n, CH_SC) && chan_event_flag[n])
          chan_armed[n] <= 1'b1;
        // every event sets flag, set wins
        if (ev)
        begin
          chan_event_flag[n] <= 1'b1;
          chan_armed[n]      <= 1'b0;
        end
        else if (wr_sc && !pwdata[CSC_FLAG] && chan_armed[n])
        begin
          chan_event_flag[n] <= 1'b0;
          chan_armed[n]      <= 1'b0;
        end
        if (wr_sc)
        begin
          wseen[n] <= 2'b00;
          wfull[n] <= 1'b0;
        end
        else if (mode != TCM_CAPTURE && debug_mode && (wr_vh || wr_vl))
        begin
          // debug writes go straight to the active value
          if (wr_vh)
            cval[n][15:8] <= pwdata[7:0];
          else
            cval[n][7:0] <= pwdata[7:0];
        end
        else if (mode != TCM_CAPTURE && (wr_vh || wr_vl))
        begin
          if (wr_vh)
            wbuf[n][15:8] <= pwdata[7:0];
          else
            wbuf[n][7:0] <= pwdata[7:0];
          if ((wseen[n] | {wr_vh, wr_vl}) == 2'b11)
          begin
            wseen[n] <= 2'b00;
            wfull[n] <= 1'b1;
          end
          else
            wseen[n] <= wseen[n] | {wr_vh, wr_vl};
        end
        else if (load)
        begin
          // completed buffer becomes the active value
          cval[n]  <= wbuf[n];
          wfull[n] <= 1'b0;
        end
        if (cap_ev)
          cval[n] <= count;
      end
    end

    // read coherency: first read latches the other half
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rhold[n]  <= 8'h00;
        rstate[n] <= 2'b00;
      end
      else if (wr_sc || debug_mode)
      begin
        // control write resets; debug freezes the state, which is kept on resume
        if (wr_sc)
          rstate[n] <= 2'b00;
      end
      else if (rd_vh)
      begin
        rstate[n] <= (rstate[n] == 2'b10) ? 2'b00 : 2'b01;
        rhold[n]  <= (rstate[n] == 2'b10) ? rhold[n] : cval[n][7:0];
      end
      else if (rd_vl)
      begin
        rstate[n] <= (rstate[n] == 2'b01) ? 2'b00 : 2'b10;
        rhold[n]  <= (rstate[n] == 2'b01) ? rhold[n] : cval[n][15:8];
      end
    end

    // pin output per mode
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        chan_pin_out[n]  <= 1'b0;
        chan_pin_oe_n[n] <= 1'b1;
      end
      else
      begin
        chan_pin_oe_n[n] <= (mode == TCM_CAPTURE) | ~(elb | ela);
        case (mode)
          TCM_COMPARE:
            if (match)
              chan_pin_out[n] <= (elb & ela) ? 1'b1 : (elb ? 1'b0 : ~chan_pin_out[n]);
          // overflow raises, match lowers; 0 stays low
          TCM_EDGE_ALIGNED_PWM:
            if (tick && at_top)
              chan_pin_out[n] <= (cval[n] == 16'h0000) ? ela : ~ela;
            else if (edge_aligned_pwm_fall)
              chan_pin_out[n] <= ela;
          // up match clears, down match sets
          TCM_CENTER_ALIGNED_PWM:
            if (cval[n][15] || cval[n] == 16'h0000)
              chan_pin_out[n] <= ela;
            // no match above the modulus: hold the active level
            else if (cval[n] > term)
              chan_pin_out[n] <= ~ela;
            else if (match)
              chan_pin_out[n] <= count_down ? ~ela : ela;
          default:
            chan_pin_out[n] <= chan_pin_out[n];
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        chan_irq[n] <= 1'b0;
      else
        chan_irq[n] <= chan_event_flag[n] & csc[n][CSC_IE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_irq <= 1'b0;
    else
      overflow_irq <= overflow_flag & tsc[TSC_OVIE];
  end

  // read mux, registered in the setup cycle answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
    begin
      prdata <= 32'h0000_0000;
      case (paddr)
        ADDR_TSC:  prdata[7:0] <= tsc | {overflow_flag, 7'h00};
        ADDR_CNTH: prdata[7:0] <= count[15:8];
        ADDR_CNTL: prdata[7:0] <= count[7:0];
        ADDR_MODH: prdata[7:0] <= modulus[15:8];
        ADDR_MODL: prdata[7:0] <= modulus[7:0];
        ADDR_DBG:  prdata[0]   <= debug_mode;
        default:   prdata <= 32'h0000_0000;
      endcase
      for (int n = 0; n < NCH; n++)
      begin
        if (chan_hit(paddr, n, CH_SC))
          prdata[7:0] <= csc[n] | {chan_event_flag[n], 7'h00};
        if (chan_hit(paddr, n, CH_VH))
          prdata[7:0] <= (rstate[n] == 2'b10 && !debug_mode) ? rhold[n] : cval[n][15:8];
        if (chan_hit(paddr, n, CH_VL))
          prdata[7:0] <= (rstate[n] == 2'b01 && !debug_mode) ? rhold[n] : cval[n][7:0];
      end
    end
  end

endmodule // tcm_timer
